// file: rtl/nvwu_pkg.sv
package nvwu_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_ADDR_LOW  = 8'h00;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
  localparam logic [7:0] OFS_DATA_LOW  = 8'h08;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h0c;
  localparam logic [7:0] OFS_CONTROL   = 8'h10;
  localparam logic [7:0] OFS_KEY       = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h1c;
  // Control field positions
  localparam int BIT_READ   = 0;
  localparam int BIT_WRITE  = 1;
  localparam int BIT_PERMIT = 2;
  localparam int BIT_SPACE  = 7;
  // Status field positions
  localparam int BIT_DONE   = 0;
  localparam int BIT_STALL  = 1;
  // Unlock keys
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Default write cycle length in clock cycles
  localparam int WRITE_CYCLES = 16;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Unlock detector states
  typedef enum logic [1:0] {
    UNL_IDLE  = 2'b00,
    UNL_FIRST = 2'b01,
    UNL_ARMED = 2'b11
  } nvwu_unlock_t;
endpackage

// file: rtl/nvwu_write_timer.sv
`timescale 1ns/1ns
`default_nettype none
module nvwu_write_timer #(
  parameter int CYCLES = 16
) (
  input  wire logic aclk,     // System clock
  input  wire logic aresetn,  // Sync reset, low
  input  wire logic start,    // Begin a write cycle
  output logic      busy,     // Write cycle running
  output logic      finish    // One-cycle end pulse
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] count_reg;

  // Count the write cycle down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= '0;
      busy      <= 1'b0;
      finish    <= 1'b0;
    end else begin
      finish <= 1'b0;
      if (start && !busy) begin
        count_reg <= CW'(CYCLES - 1);
        busy      <= 1'b1;
      end else if (busy) begin
        if (count_reg == '0) begin
          busy   <= 1'b0;
          finish <= 1'b1;
        end else begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/nvwu_top.sv
// Notes on behaviour
// (R1) Byte write starts only after key 55h, key AAh, then trigger set.
// (R2) Write trigger cannot be set while write permit is clear.
// (R3) Write permit changes only by software writes, never by hardware.
// (R4) Clearing permit during a write does not abort that write.
// (R5) Write end clears write trigger and sets write done flag.
// (R6) Write done flag stays set until software clears it.
// (R7) Write done flag drives an interrupt when enabled, else polled.
// (R8) Software loads address and data before the unlock sequence.
// (R9) Software should mask interrupts during the unlock sequence.
// (R10) Software keeps write permit clear except while updating storage.
// (R11) Flash read: load addresses, select program space, set read trigger.
// (R12) Slot after read trigger runs; second slot ignored during read.
// (R13) Fetched word appears in data low and high next cycle.
// (R14) Data registers hold fetched word until next read or write.
// (R15) Software places two no-ops after a program-space read trigger.
// (R16) Write trigger set with program space selected clears at once.
// (R17) Read trigger set only by software; hardware clears it.
// (R18) Select bit clear targets data storage, set targets program Flash.
// (R19) Key writes and trigger write must be consecutive register writes.
// (R20) Fetch stalls exactly one slot; word latched at slot end.
`timescale 1ns/1ns
`default_nettype none
module nvwu_top #(
  parameter int WRITE_CYCLES = nvwu_pkg::WRITE_CYCLES
) (
  input  wire logic        aclk,          // System clock
  input  wire logic        aresetn,       // Sync reset, low
  input  wire logic [7:0]  s_awaddr,      // Write address
  input  wire logic        s_awvalid,     // Write address valid
  output logic             s_awready,     // Write address ready
  input  wire logic [31:0] s_wdata,       // Write data
  input  wire logic [3:0]  s_wstrb,       // Write strobes
  input  wire logic        s_wvalid,      // Write data valid
  output logic             s_wready,      // Write data ready
  output logic [1:0]       s_bresp,       // Write response
  output logic             s_bvalid,      // Write response valid
  input  wire logic        s_bready,      // Write response ready
  input  wire logic [7:0]  s_araddr,      // Read address
  input  wire logic        s_arvalid,     // Read address valid
  output logic             s_arready,     // Read address ready
  output logic [31:0]      s_rdata,       // Read data
  output logic [1:0]       s_rresp,       // Read response
  output logic             s_rvalid,      // Read data valid
  input  wire logic        s_rready,      // Read data ready
  output logic [7:0]       ee_addr,       // Data EEPROM address
  output logic [7:0]       ee_wdata,      // Data EEPROM byte
  output logic             ee_write,      // Data EEPROM write active
  output logic [15:0]      flash_addr,    // Program Flash address
  output logic             flash_rd,      // Program Flash read strobe
  input  wire logic [15:0] flash_rdata,   // Program Flash word
  output logic             fetch_stall,   // Core fetch stall
  output logic             write_done_irq // Write done interrupt
);
  logic [7:0]   nv_addr_low_reg;
  logic [7:0]   nv_addr_high_reg;
  logic [7:0]   nv_data_low_reg;
  logic [7:0]   nv_data_high_reg;
  logic         program_space_select_reg;
  logic         write_permit_reg;
  logic         write_trig_reg;
  logic         read_trig_reg;
  logic         write_done_flag_reg;
  logic         irq_en_reg;
  logic         stall_reg;
  nvwu_pkg::nvwu_unlock_t unl_reg;
  nvwu_pkg::nvwu_unlock_t unl_next;
  logic         aw_held;
  logic         w_held;
  logic [7:0]   aw_addr;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;
  logic         wr_fire;
  logic         timer_busy;
  logic         timer_finish;
  logic         start_write;
  logic         wr_ctrl;
  logic         wr_key;
  logic         set_wr_req;
  logic         set_rd_req;

  // Write channel capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_held <= 1'b1;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  assign wr_fire = aw_held && w_held && !s_bvalid;

  // Ready and response flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= nvwu_pkg::RESP_OKAY;
    end else begin
      s_awready <= !aw_held && !(s_awvalid && s_awready) && !s_bvalid;
      s_wready  <= !w_held && !(s_wvalid && s_wready) && !s_bvalid;
      if (wr_fire) begin
        s_bvalid <= 1'b1;
        s_bresp  <= (aw_addr > nvwu_pkg::OFS_IRQ_EN || aw_addr[1:0] != 2'b00)
                    ? nvwu_pkg::RESP_SLVERR : nvwu_pkg::RESP_OKAY;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // Decoded byte-lane writes
  assign wr_ctrl = wr_fire && w_strb[0] && aw_addr == nvwu_pkg::OFS_CONTROL;
  assign wr_key  = wr_fire && w_strb[0] && aw_addr == nvwu_pkg::OFS_KEY;
  assign set_wr_req = wr_ctrl && w_data[nvwu_pkg::BIT_WRITE];
  assign set_rd_req = wr_ctrl && w_data[nvwu_pkg::BIT_READ];

  // Unlock detector
  always_comb begin
    unl_next = unl_reg;
    if (wr_fire) begin
      unique case (unl_reg)
        nvwu_pkg::UNL_IDLE:
          unl_next = (wr_key && w_data[7:0] == nvwu_pkg::KEY_FIRST)
                     ? nvwu_pkg::UNL_FIRST : nvwu_pkg::UNL_IDLE; // R1
        nvwu_pkg::UNL_FIRST:
          unl_next = (wr_key && w_data[7:0] == nvwu_pkg::KEY_SECOND)
                     ? nvwu_pkg::UNL_ARMED : nvwu_pkg::UNL_IDLE; // R19
        nvwu_pkg::UNL_ARMED:
          unl_next = nvwu_pkg::UNL_IDLE; // R1
        default:
          unl_next = nvwu_pkg::UNL_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) unl_reg <= nvwu_pkg::UNL_IDLE;
    else          unl_reg <= unl_next;
  end

  // A write starts on armed trigger write in data space with permit
  assign start_write = set_wr_req && unl_reg == nvwu_pkg::UNL_ARMED
                       && write_permit_reg && !w_data[nvwu_pkg::BIT_SPACE]
                       && !write_trig_reg; // R1 R2 R16 R18

  nvwu_write_timer #(
    .CYCLES (WRITE_CYCLES)
  ) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (start_write),
    .busy    (timer_busy),
    .finish  (timer_finish)
  );

  // Control bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      program_space_select_reg <= 1'b0;
      write_permit_reg         <= 1'b0;
      write_trig_reg           <= 1'b0;
      read_trig_reg            <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        program_space_select_reg <= w_data[nvwu_pkg::BIT_SPACE]; // R18
        write_permit_reg <= w_data[nvwu_pkg::BIT_PERMIT]; // R3 R4
      end
      if (start_write)
        write_trig_reg <= 1'b1; // R2
      else if (timer_finish)
        write_trig_reg <= 1'b0; // R5
      // Read trigger lives one cycle, then clears itself
      if (set_rd_req)
        read_trig_reg <= 1'b1; // R17
      else if (read_trig_reg)
        read_trig_reg <= 1'b0; // R17
    end
  end

  // Write done flag, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_done_flag_reg <= 1'b0;
      irq_en_reg          <= 1'b0;
    end else begin
      if (timer_finish)
        write_done_flag_reg <= 1'b1; // R5
      else if (wr_fire && w_strb[0] && aw_addr == nvwu_pkg::OFS_STATUS
               && w_data[nvwu_pkg::BIT_DONE])
        write_done_flag_reg <= 1'b0; // R6
      if (wr_fire && w_strb[0] && aw_addr == nvwu_pkg::OFS_IRQ_EN)
        irq_en_reg <= w_data[0];
    end
  end

  // Address and data registers, Flash word capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nv_addr_low_reg  <= nvwu_pkg::RST_BYTE;
      nv_addr_high_reg <= nvwu_pkg::RST_BYTE;
      nv_data_low_reg  <= nvwu_pkg::RST_BYTE;
      nv_data_high_reg <= nvwu_pkg::RST_BYTE;
    end else begin
      if (wr_fire && w_strb[0] && aw_addr == nvwu_pkg::OFS_ADDR_LOW)
        nv_addr_low_reg <= w_data[7:0];
      if (wr_fire && w_strb[0] && aw_addr == nvwu_pkg::OFS_ADDR_HIGH)
        nv_addr_high_reg <= w_data[7:0];
      if (stall_reg) begin
        nv_data_low_reg  <= flash_rdata[7:0];  // R13 R20
        nv_data_high_reg <= flash_rdata[15:8]; // R13
      end else begin
        if (wr_fire && w_strb[0] && aw_addr == nvwu_pkg::OFS_DATA_LOW)
          nv_data_low_reg <= w_data[7:0]; // R14
        if (wr_fire && w_strb[0] && aw_addr == nvwu_pkg::OFS_DATA_HIGH)
          nv_data_high_reg <= w_data[7:0]; // R14
      end
    end
  end

  // One stall slot after the slot following a program read trigger
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stall_reg <= 1'b0;
      flash_rd  <= 1'b0;
    end else begin
      flash_rd  <= read_trig_reg && program_space_select_reg; // R12
      stall_reg <= flash_rd; // R12 R20
    end
  end

  // Array-side outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ee_addr        <= 8'h00;
      ee_wdata       <= 8'h00;
      ee_write       <= 1'b0;
      flash_addr     <= 16'h0000;
      fetch_stall    <= 1'b0;
      write_done_irq <= 1'b0;
    end else begin
      ee_addr        <= nv_addr_low_reg;
      ee_wdata       <= nv_data_low_reg;
      ee_write       <= timer_busy; // R4
      flash_addr     <= {nv_addr_high_reg, nv_addr_low_reg};
      fetch_stall    <= flash_rd; // R20
      write_done_irq <= write_done_flag_reg && irq_en_reg; // R7
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0;
      s_rresp   <= nvwu_pkg::RESP_OKAY;
    end else begin
      s_arready <= !s_rvalid && !(s_arvalid && s_arready);
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rresp  <= nvwu_pkg::RESP_OKAY;
        unique case (s_araddr)
          nvwu_pkg::OFS_ADDR_LOW:  s_rdata <= {24'h0, nv_addr_low_reg};
          nvwu_pkg::OFS_ADDR_HIGH: s_rdata <= {24'h0, nv_addr_high_reg};
          nvwu_pkg::OFS_DATA_LOW:  s_rdata <= {24'h0, nv_data_low_reg};
          nvwu_pkg::OFS_DATA_HIGH: s_rdata <= {24'h0, nv_data_high_reg};
          nvwu_pkg::OFS_CONTROL:   s_rdata <= {24'h0,
              program_space_select_reg, 4'h0, write_permit_reg,
              write_trig_reg, read_trig_reg};
          nvwu_pkg::OFS_KEY:       s_rdata <= 32'h0;
          nvwu_pkg::OFS_STATUS:    s_rdata <= {30'h0, stall_reg,
              write_done_flag_reg}; // R7
          nvwu_pkg::OFS_IRQ_EN:    s_rdata <= {31'h0, irq_en_reg};
          default: begin
            s_rdata <= 32'h0;
            s_rresp <= nvwu_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  sequence unlock_seq;
    unl_reg == nvwu_pkg::UNL_ARMED;
  endsequence

  unlock_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start_write |-> unlock_seq) else $error("write without unlock"); // R1
  permit_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(write_trig_reg) |-> $past(write_permit_reg))
    else $error("trigger set without permit"); // R2
  permit_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !wr_ctrl |=> $stable(write_permit_reg))
    else $error("permit changed by hardware"); // R3
  write_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start_write |=> timer_busy [*8]) else $error("write aborted"); // R4
  done_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_finish |=> write_done_flag_reg && !write_trig_reg)
    else $error("done not flagged"); // R5
  done_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(write_done_flag_reg) |-> $past(wr_fire))
    else $error("done cleared by hardware"); // R6
  done_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    write_done_flag_reg && irq_en_reg |=> write_done_irq)
    else $error("irq missing"); // R7
  space_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    set_wr_req && w_data[nvwu_pkg::BIT_SPACE] |=> !write_trig_reg[*2])
    else $error("program space write ran"); // R16
  read_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    read_trig_reg && !set_rd_req |=> !read_trig_reg)
    else $error("read trigger stuck"); // R17
  stall_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(read_trig_reg) && program_space_select_reg
    |=> !fetch_stall ##1 fetch_stall ##1 !fetch_stall)
    else $error("stall slot wrong"); // R12 R20
  word_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    stall_reg |=> nv_data_low_reg == $past(flash_rdata[7:0])
    && nv_data_high_reg == $past(flash_rdata[15:8]))
    else $error("word not latched"); // R13
  data_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !stall_reg && !wr_fire |=> $stable(nv_data_low_reg))
    else $error("data changed"); // R14
  key_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && !wr_key && unl_reg != nvwu_pkg::UNL_ARMED
    |=> unl_reg == nvwu_pkg::UNL_IDLE)
    else $error("unlock not reset"); // R19
endmodule
`default_nettype wire

// file: bench/nvwu_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
// Program Flash array answering the read strobe with one word
module nvwu_flash_model (
  input  wire logic        aclk,  // System clock
  input  wire logic [15:0] addr,  // Word address
  input  wire logic        rd,    // Read strobe
  output logic      [15:0] rdata  // Word out
);
  logic [15:0] word_reg = 16'h0000;
  logic [1:0]  hold_reg = 2'h0;
  // Word holds briefly after the strobe, then churns so nothing stale passes
  always_ff @(posedge aclk) begin
    if (rd) begin
      word_reg <= addr ^ 16'hc35a;
      hold_reg <= 2'h2;
    end else if (hold_reg != 2'h0) begin
      hold_reg <= hold_reg - 2'h1;
    end else begin
      word_reg <= ~word_reg;
    end
  end
  assign rdata = word_reg;
endmodule
`default_nettype wire

// file: bench/nvwu_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module nvwu_top_tb;
  localparam int WC = 12;
  localparam logic [7:0] AL  = nvwu_pkg::OFS_ADDR_LOW;
  localparam logic [7:0] AH  = nvwu_pkg::OFS_ADDR_HIGH;
  localparam logic [7:0] DL  = nvwu_pkg::OFS_DATA_LOW;
  localparam logic [7:0] DH  = nvwu_pkg::OFS_DATA_HIGH;
  localparam logic [7:0] CTL = nvwu_pkg::OFS_CONTROL;
  localparam logic [7:0] KEY = nvwu_pkg::OFS_KEY;
  localparam logic [7:0] ST  = nvwu_pkg::OFS_STATUS;
  localparam logic [7:0] IE  = nvwu_pkg::OFS_IRQ_EN;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_awaddr = 8'h00;
  logic [7:0]  s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic        s_awvalid = 1'b0;
  logic        s_wvalid = 1'b0;
  logic        s_bready = 1'b0;
  logic        s_arvalid = 1'b0;
  logic        s_rready = 1'b0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic [7:0]  ee_addr, ee_wdata;
  logic        ee_write, flash_rd, fetch_stall, write_done_irq;
  logic [15:0] flash_addr, flash_rdata, rd_a, fa;
  logic [7:0]  ee_a, ee_d;
  logic        prev_rd = 1'b0;
  logic [15:0] bad [6][4];
  logic [7:0]  bexp [6];
  int          n_mismatch = 0;
  int          compares = 0;
  int          ee_cnt = 0;
  int          stall_cnt = 0;
  int          base;

  nvwu_top #(.WRITE_CYCLES(WC)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(4'hf), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .ee_addr(ee_addr),
    .ee_wdata(ee_wdata), .ee_write(ee_write), .flash_addr(flash_addr),
    .flash_rd(flash_rd), .flash_rdata(flash_rdata),
    .fetch_stall(fetch_stall), .write_done_irq(write_done_irq)
  );

  nvwu_flash_model flash (
    .aclk(aclk), .addr(flash_addr), .rd(flash_rd), .rdata(flash_rdata)
  );

  // Clock, 4 ns period
  always #2 aclk = ~aclk;

  // Counts write-cycle and stall slots, captures what the arrays saw
  always @(posedge aclk) begin
    if (ee_write === 1'b1) begin
      ee_cnt++;
      ee_a <= ee_addr;
      ee_d <= ee_wdata;
    end
    if (fetch_stall === 1'b1) begin
      stall_cnt++;
      check({31'h0, prev_rd}, 32'h1);
    end
    if (flash_rd === 1'b1)
      rd_a <= flash_addr;
    prev_rd <= flash_rd;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Bounded wait for a bus answer
  task automatic tick(inout int n);
    n++;
    if (n > 50) begin
      n_mismatch++;
      results();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= {24'h0, d};
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready === 1'b1)
        s_awvalid <= 1'b0;
      if (s_wready === 1'b1)
        s_wvalid <= 1'b0;
      tick(n);
    end while (s_bvalid !== 1'b1);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready === 1'b1)
        s_arvalid <= 1'b0;
      tick(n);
    end while (s_rvalid !== 1'b1);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check({30'h0, r}, 32'h0);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check({r, d[29:0]}, {2'b00, e[29:0]});
  endtask

  // Full unlock and trigger, then poll the done flag
  task automatic ee_write_byte(input logic [7:0] d);
    logic [31:0] s;
    logic [1:0]  r;
    int          n;
    n = 0;
    w(DL, d);
    w(KEY, 8'h55);
    w(KEY, 8'haa);
    w(CTL, 8'h06);
    do begin
      rd(ST, s, r);
      tick(n);
    end while (s[0] !== 1'b1);
  endtask

  // Watchdog
  initial begin
    repeat (10000) @(posedge aclk);
    n_mismatch++;
    results();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    bad = '{'{16'h1006, 16'hffff, 16'hffff, 16'hffff},
            '{16'h1000, 16'h1455, 16'h14aa, 16'h1002},
            '{16'h1004, 16'h14aa, 16'h1455, 16'h1006},
            '{16'h1455, 16'h0811, 16'h14aa, 16'h1006},
            '{16'h1455, 16'h1006, 16'hffff, 16'hffff},
            '{16'h1455, 16'h14aa, 16'h1086, 16'hffff}};
    bexp = '{8'h04, 8'h00, 8'h04, 8'h04, 8'h04, 8'h84};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values and refused addresses
    for (int i = 0; i < 8; i++)
      rc(8'(i * 4), 32'h0);
    wr(8'h20, 8'h01, r);
    check({30'h0, r}, {30'h0, nvwu_pkg::RESP_SLVERR});
    rd(8'h02, d, r);
    check({30'h0, r}, {30'h0, nvwu_pkg::RESP_SLVERR});
    $display("test reset done");
    // Guarded byte write, permit dropped mid-cycle
    w(AL, 8'h3c);
    w(CTL, 8'h04);
    w(DL, 8'h96);
    w(KEY, 8'h55);
    w(KEY, 8'haa);
    w(CTL, 8'h06);
    w(CTL, 8'h00);
    repeat (WC + 4) @(posedge aclk);
    rc(ST, 32'h1);
    check(ee_cnt, WC);
    check({ee_a, ee_d}, 32'h3c96);
    rc(CTL, 32'h0);
    check(write_done_irq, 1'b0);
    w(IE, 8'h01);
    @(negedge aclk);
    check(write_done_irq, 1'b1);
    rc(ST, 32'h1);
    w(ST, 8'h01);
    rc(ST, 32'h0);
    check(write_done_irq, 1'b0);
    $display("test byte write done");
    // Permit kept across a second write
    w(CTL, 8'h04);
    ee_write_byte(8'ha5);
    rc(CTL, 32'h04);
    check({24'(ee_cnt), ee_d}, {24'(WC * 2), 8'ha5});
    w(ST, 8'h01);
    $display("test permit kept done");
    // Broken sequences start nothing
    for (int i = 0; i < 6; i++) begin
      base = ee_cnt;
      for (int j = 0; j < 4; j++)
        if (bad[i][j] != 16'hffff)
          w(bad[i][j][15:8], bad[i][j][7:0]);
      repeat (WC + 8) @(posedge aclk);
      check(ee_cnt, base);
      rc(CTL, {24'h0, bexp[i]});
      rc(ST, 32'h0);
    end
    $display("test refusals done");
    // Program Flash word reads, boundary address last
    for (int i = 0; i < 2; i++) begin
      fa = (i == 0) ? 16'h1234 : 16'hffff;
      w(AH, fa[15:8]);
      w(AL, fa[7:0]);
      w(CTL, 8'h81);
      repeat (2) @(posedge aclk);
      rc(DL, {24'h0, fa[7:0] ^ 8'h5a});
      rc(DH, {24'h0, fa[15:8] ^ 8'hc3});
      check({rd_a, 16'(stall_cnt)}, {fa, 16'(i + 1)});
      rc(CTL, 32'h80);
    end
    w(DL, 8'h5a);
    rc(DL, 32'h5a);
    rc(DH, 32'h3c);
    $display("test flash read done");
    results();
  end
endmodule
`default_nettype wire
